//--- ras_pkg.sv
package ras_pkg;

	// Location numbers on the serial parameter port
	localparam logic [7:0] LOC_AUX_COEF = 8'h0e;
	localparam logic [7:0] LOC_STARTUP_SLOPE = 8'h18;
	localparam logic [7:0] LOC_SC_TIME = 8'h19;
	localparam logic [7:0] LOC_OVERSPEED = 8'h1a;
	localparam logic [7:0] LOC_ALARM_STATUS = 8'h26;

	// Reset values of the writable parameters
	localparam logic [15:0] AUX_COEF_RESET = 16'h0000;
	localparam logic [15:0] STARTUP_SLOPE_RESET = 16'h2ee0;
	localparam logic [15:0] SC_TIME_RESET = 16'h0014;
	localparam logic [15:0] OVERSPEED_RESET = 16'h0000;

	// Frequencies in hundredths of a hertz
	localparam logic [15:0] OVS_BASE_LOW = 16'h157c;
	localparam logic [15:0] OVS_BASE_HIGH = 16'h19c8;
	localparam logic [15:0] OVS_SPAN_LOW = 16'h01f4;
	localparam logic [15:0] OVS_SPAN_HIGH = 16'h0258;
	localparam logic [15:0] SWITCH_OFF_FREQ = 16'h07d0;

	// Fixed-point helpers for the signed / coefficient scaling
	localparam logic [31:0] Q15_HALF = 32'h0000_4000;
	localparam int Q15_SHIFT = 15;
	localparam logic [16:0] WRAP_16 = 17'h1_0000;

	// Timing: clock, tenth of a second, flash period, protection delay
	localparam int CLK_PERIOD_NS = 5;
	localparam int TENTH_NS = 100_000_000;
	localparam int TENTH_CYCLES = TENTH_NS / CLK_PERIOD_NS;
	localparam int FLASH_PERIOD_MS = 2000;
	localparam int FLASH_CYCLES = (FLASH_PERIOD_MS / CLK_PERIOD_NS) * 1_000_000;
	localparam int FLASH_ALARM_DIV = 4;
	localparam logic [7:0] TENTHS_PER_S = 8'h0a;

	// Status word bit positions
	localparam int ST_OK_BIT = 11;
	localparam int ST_RANGE_BIT = 15;
	localparam int NUM_ALARMS = 7;

	// Alarm status word layout
	typedef struct packed {
		logic range_sel;
		logic [2:0] rsv_hi;
		logic ok;
		logic [3:0] rsv_lo;
		logic overspeed;
		logic underspeed;
		logic over_excitation;
		logic short_circuit;
		logic under_voltage;
		logic over_voltage;
		logic checksum;
	} ras_status_t;

	// Parameter port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} ras_loc_req_t;

	// Regulator supervisory states
	typedef enum logic [3:0] {
		ST_START = 4'b0001,
		ST_RUN = 4'b0010,
		ST_OFF = 4'b0100,
		ST_BLOCKED = 4'b1000
	} ras_state_t;

endpackage : ras_pkg

//--- ras_flash.sv
`timescale 1ns/10ps
`default_nettype none

module ras_flash import ras_pkg::*; #(
	parameter int PERIOD_CYCLES = FLASH_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pattern select
	input wire logic alarm_active,
	// Indicator drive
	output logic led
);

	logic [31:0] cnt;
	logic [31:0] period;
	logic [31:0] half;

	// Normal slow blink, faster when an alarm or intervention is present
	always_comb begin
		period = alarm_active ? 32'(PERIOD_CYCLES / FLASH_ALARM_DIV) : 32'(PERIOD_CYCLES);
		half = {1'b0, period[31:1]};
	end

	// Period counter, restarted by range check when a pattern change to the shorter period leaves it out of range
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 32'h0000_0000;
		end else if (cnt >= period - 32'h0000_0001) begin
			cnt <= 32'h0000_0000;
		end else begin
			cnt <= cnt + 32'h0000_0001;
		end
	end

	// 50% duty lamp
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			led <= 1'b0;
		end else begin
			led <= (cnt < half); // see [R17]
		end
	end

endmodule : ras_flash

`default_nettype wire

//--- ras_supervisor.sv
// What this block does
// [R1] Zero overspeed setting: 55 or 66 Hz
// [R2] Negative setting lowers threshold toward 50/60
// [R3] Positive setting raises threshold toward 60/72
// [R4] Floor on reduced voltage below underspeed
// [R5] Direct supply: software writes coefficient zero
// [R6] Aux supply: coefficient from voltage ratio
// [R7] Start-up slope until underspeed threshold passed
// [R8] Start-up slope resets to 12000
// [R9] Short-circuit timer in tenths, then block
// [R10] Short-circuit time zero never blocks
// [R11] Checksum failure restores defaults and blocks
// [R12] Short circuit: protection, max current, block
// [R13] Excitation overcurrent: protection, reduce current
// [R14] Active alarms readable at location 38
// [R15] Bit index plus one is alarm number
// [R16] Bit 11 high when no alarm
// [R17] Indicator blinks every 2 s, 50%; the code blinks every 0.5 s while any alarm is present
// [R18] Off below 20 Hz until full stop
// [R19] Masked alarms close output after delay
// [R20] Reserved bits zero, alarms live
// [R21] Short-circuit count restarts when condition clears
`timescale 1ns/10ps
`default_nettype none

module ras_supervisor import ras_pkg::*; #(
	parameter int TENTH_CYC = TENTH_CYCLES,
	parameter int FLASH_CYC = FLASH_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Serial parameter port
	input wire ras_loc_req_t loc_req,
	output logic [15:0] loc_rdata,
	output logic loc_rvalid,
	// Measurements and strap
	input wire logic [15:0] freq,
	input wire logic [15:0] underspeed_freq,
	input wire logic high_freq_range_select,
	// Alarm conditions from the regulator
	input wire logic checksum_fail,
	input wire logic over_voltage,
	input wire logic under_voltage,
	input wire logic short_circuit,
	input wire logic excit_overcurrent,
	// Protection output setup
	input wire logic [6:0] prot_mask,
	input wire logic [3:0] prot_delay_s,
	// Voltage shaping
	input wire logic [15:0] run_vf_slope,
	input wire logic [15:0] vout_request,
	input wire logic [15:0] aux_supply_min,
	// Regulator actions
	output logic protection_output,
	output logic max_excitation,
	output logic reduce_excitation,
	output logic regulator_enable,
	output logic [15:0] active_vf_slope,
	output logic [15:0] vout_setpoint,
	output ras_status_t status_word,
	output logic indicator_led
);

	logic rst_meta;
	logic rst_n;
	logic [15:0] aux_voltage_coefficient;
	logic [15:0] startup_vf_slope;
	logic [15:0] short_circuit_time;
	logic [15:0] overspeed_threshold;
	ras_state_t state;
	ras_state_t next_state;
	logic startup_phase;
	logic [15:0] ovs_base;
	logic [15:0] ovs_span;
	logic [15:0] ovs_mag;
	logic [31:0] ovs_prod;
	logic [15:0] ovs_offset;
	logic [15:0] ovs_limit;
	logic [31:0] floor_prod;
	logic [15:0] vout_floor;
	logic [31:0] tenth_cnt;
	logic tenth_tick;
	logic [7:0] sc_tenths;
	logic sc_expired;
	logic [7:0] prot_tenths;
	logic [7:0] prot_limit;
	logic checksum_alarm;
	logic sc_alarm;
	logic [6:0] alarms;
	logic prot_request;
	logic underspeed_alarm;
	logic overspeed_alarm;
	logic any_alarm;

	// Reset release through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Parameter writes; a checksum failure reloads defaults
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aux_voltage_coefficient <= AUX_COEF_RESET;
			startup_vf_slope <= STARTUP_SLOPE_RESET; // see [R8]
			short_circuit_time <= SC_TIME_RESET;
			overspeed_threshold <= OVERSPEED_RESET;
		end else if (checksum_fail) begin
			aux_voltage_coefficient <= AUX_COEF_RESET; // see [R11]
			startup_vf_slope <= STARTUP_SLOPE_RESET;
			short_circuit_time <= SC_TIME_RESET;
			overspeed_threshold <= OVERSPEED_RESET;
		end else if (loc_req.wr) begin
			unique case (loc_req.addr)
				LOC_AUX_COEF: aux_voltage_coefficient <= loc_req.wdata; // see [R5]
				LOC_STARTUP_SLOPE: startup_vf_slope <= loc_req.wdata;
				LOC_SC_TIME: short_circuit_time <= {8'h00, loc_req.wdata[7:0]};
				LOC_OVERSPEED: overspeed_threshold <= loc_req.wdata;
				default: ;
			endcase
		end
	end

	// Parameter reads, one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loc_rdata <= 16'h0000;
			loc_rvalid <= 1'b0;
		end else begin
			loc_rvalid <= loc_req.rd;
			if (loc_req.rd) begin
				unique case (loc_req.addr)
					LOC_AUX_COEF: loc_rdata <= aux_voltage_coefficient;
					LOC_STARTUP_SLOPE: loc_rdata <= startup_vf_slope;
					LOC_SC_TIME: loc_rdata <= short_circuit_time;
					LOC_OVERSPEED: loc_rdata <= overspeed_threshold;
					LOC_ALARM_STATUS: loc_rdata <= status_word; // see [R14]
					default: loc_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// Overspeed limit: base point plus or minus a scaled offset
	always_comb begin
		ovs_base = high_freq_range_select ? OVS_BASE_HIGH : OVS_BASE_LOW; // see [R1]
		ovs_span = high_freq_range_select ? OVS_SPAN_HIGH : OVS_SPAN_LOW;
		if (overspeed_threshold[15]) begin
			ovs_mag = 16'(WRAP_16 - {1'b0, overspeed_threshold}); // see [R2]
		end else begin
			ovs_mag = overspeed_threshold; // see [R3]
		end
		ovs_prod = 32'(ovs_mag) * 32'(ovs_span) + Q15_HALF;
		ovs_offset = 16'(ovs_prod >> Q15_SHIFT);
		if (overspeed_threshold[15]) begin
			ovs_limit = ovs_base - ovs_offset; // see [R2]
		end else begin
			ovs_limit = ovs_base + ovs_offset; // see [R3]
		end
	end

	// Lowest output voltage that still feeds the regulator supply
	always_comb begin
		floor_prod = 32'(aux_supply_min) * 32'(aux_voltage_coefficient) + Q15_HALF; // see [R6]
		vout_floor = aux_supply_min + 16'(floor_prod >> Q15_SHIFT); // see [R4]
	end

	// Tenth-of-a-second time base
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tenth_cnt <= 32'h0000_0000;
			tenth_tick <= 1'b0;
		end else if (tenth_cnt == 32'(TENTH_CYC - 1)) begin
			tenth_cnt <= 32'h0000_0000;
			tenth_tick <= 1'b1;
		end else begin
			tenth_cnt <= tenth_cnt + 32'h0000_0001;
			tenth_tick <= 1'b0;
		end
	end

	// Live alarm conditions
	always_comb begin
		sc_alarm = short_circuit && (freq >= SWITCH_OFF_FREQ) && (state == ST_RUN);
		underspeed_alarm = (freq < underspeed_freq);
		overspeed_alarm = (freq > ovs_limit); // see [R1]
		alarms = {overspeed_alarm, underspeed_alarm, excit_overcurrent, sc_alarm,
			under_voltage, over_voltage, checksum_alarm}; // see [R15]
		any_alarm = |alarms;
		sc_expired = (short_circuit_time[7:0] != 8'h00) && (sc_tenths >= short_circuit_time[7:0]); // see [R10]
	end

	// Short-circuit tolerance count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sc_tenths <= 8'h00;
		end else if (!sc_alarm) begin
			sc_tenths <= 8'h00; // see [R21]
		end else if (tenth_tick && !sc_expired && (sc_tenths != 8'hff)) begin
			sc_tenths <= sc_tenths + 8'h01; // see [R9]
		end
	end

	// Checksum alarm held until the machine restarts from standstill
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			checksum_alarm <= 1'b0;
		end else if (checksum_fail) begin
			checksum_alarm <= 1'b1; // see [R11]
		end else if (next_state == ST_START && state == ST_BLOCKED) begin
			checksum_alarm <= 1'b0;
		end
	end

	// Supervisory state transitions
	always_comb begin
		next_state = state;
		if (checksum_fail) begin
			next_state = ST_BLOCKED; // see [R11]
		end else begin
			unique case (state)
				ST_START: if (freq >= SWITCH_OFF_FREQ) begin
					next_state = ST_RUN;
				end
				ST_RUN: if (sc_alarm && sc_expired) begin
					next_state = ST_BLOCKED; // see [R9]
				end else if (freq < SWITCH_OFF_FREQ) begin
					next_state = ST_OFF; // see [R18]
				end
				ST_OFF: if (freq == 16'h0000) begin
					next_state = ST_START; // see [R18]
				end
				ST_BLOCKED: if (freq == 16'h0000) begin
					next_state = ST_START;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_START;
		end else begin
			state <= next_state;
		end
	end

	// Start-up slope in force until the underspeed threshold is passed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			startup_phase <= 1'b1;
		end else if (state == ST_START) begin
			startup_phase <= 1'b1;
		end else if (freq > underspeed_freq) begin
			startup_phase <= 1'b0; // see [R7]
		end
	end

	// Slope and voltage setpoint handed to the control loop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_vf_slope <= STARTUP_SLOPE_RESET;
			vout_setpoint <= 16'h0000;
		end else begin
			active_vf_slope <= startup_phase ? startup_vf_slope : run_vf_slope; // see [R7]
			if (underspeed_alarm && (vout_request < vout_floor)) begin
				vout_setpoint <= vout_floor; // see [R4]
			end else begin
				vout_setpoint <= vout_request;
			end
		end
	end

	// Protection output delay in tenths
	always_comb begin
		prot_request = (|(alarms & prot_mask)) || sc_alarm || excit_overcurrent; // see [R19]
		prot_limit = 8'(prot_delay_s * TENTHS_PER_S);
	end

	// Delay counter, restarted whenever no selected alarm, short-circuit alarm or excitation overcurrent is present
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prot_tenths <= 8'h00;
		end else if (!prot_request) begin
			prot_tenths <= 8'h00;
		end else if (tenth_tick && (prot_tenths < prot_limit)) begin
			prot_tenths <= prot_tenths + 8'h01;
		end
	end

	// Regulator action outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			protection_output <= 1'b0;
			max_excitation <= 1'b0;
			reduce_excitation <= 1'b0;
			regulator_enable <= 1'b0;
		end else begin
			protection_output <= prot_request && (prot_tenths >= prot_limit); // see [R12] [R13] [R19]
			max_excitation <= sc_alarm; // see [R12]
			reduce_excitation <= excit_overcurrent && (state == ST_RUN); // see [R13]
			regulator_enable <= (next_state == ST_RUN) || (next_state == ST_START);
		end
	end

	// Alarm status word, refreshed every cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_word <= '0;
		end else begin
			status_word.checksum <= alarms[0]; // see [R15] [R20]
			status_word.over_voltage <= alarms[1];
			status_word.under_voltage <= alarms[2];
			status_word.short_circuit <= alarms[3];
			status_word.over_excitation <= alarms[4];
			status_word.underspeed <= alarms[5];
			status_word.overspeed <= alarms[6];
			status_word.rsv_lo <= 4'h0; // see [R20]
			status_word.ok <= !any_alarm; // see [R16]
			status_word.rsv_hi <= 3'h0;
			status_word.range_sel <= high_freq_range_select;
		end
	end

	// Indicator lamp
	ras_flash #(
		.PERIOD_CYCLES(FLASH_CYC)
	) u_flash (
		.clk(clk),
		.rst_n(rst_n),
		.alarm_active(any_alarm), // see [R17]
		.led(indicator_led)
	);

endmodule : ras_supervisor

`default_nettype wire

//--- ras_supervisor_properties.sv
`timescale 1ns/10ps
`default_nettype none

module ras_supervisor_chk import ras_pkg::*; #(
	parameter int FLASH_CYC = FLASH_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Watched inputs
	input wire ras_loc_req_t loc_req,
	input wire logic high_freq_range_select,
	input wire logic over_voltage,
	input wire logic short_circuit,
	input wire logic excit_overcurrent,
	// Watched outputs
	input wire logic [15:0] loc_rdata,
	input wire logic loc_rvalid,
	input wire logic max_excitation,
	input wire logic reduce_excitation,
	input wire ras_status_t status_word,
	input wire logic indicator_led
);
	logic [2:0] up_cnt;
	logic [31:0] run_len;
	logic led_q;
	logic ready;
	// Edges since release, to skip the internal reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) up_cnt <= 3'h0;
		else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
	end
	assign ready = (up_cnt >= 3'h5);
	// Cycles spent at the current indicator level
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) run_len <= 32'h0;
		else if (indicator_led != led_q) run_len <= 32'h1;
		else run_len <= run_len + 32'h1;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) led_q <= 1'b0;
		else led_q <= indicator_led;
	end

	chk_read_answer: assert property (@(posedge clk) disable iff (!arst_n)
		ready && loc_req.rd |=> loc_rvalid) else $error("read not answered");
	chk_rvalid_cause: assert property (@(posedge clk) disable iff (!arst_n)
		loc_rvalid |-> $past(loc_req.rd)) else $error("answer without read");
	chk_rdata_hold: assert property (@(posedge clk) disable iff (!arst_n)
		ready && !loc_rvalid |-> $stable(loc_rdata)) else $error("read data moved");
	chk_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
		status_word.rsv_hi == 3'h0 && status_word.rsv_lo == 4'h0) else $error("reserved bit set");
	chk_ok_no_alarm: assert property (@(posedge clk) disable iff (!arst_n)
		ready |-> status_word.ok == (status_word[6:0] == 7'h0)) else $error("ok bit wrong");
	chk_ov_bit: assert property (@(posedge clk) disable iff (!arst_n)
		ready |-> status_word.over_voltage == $past(over_voltage)) else $error("ov bit wrong");
	chk_range_bit: assert property (@(posedge clk) disable iff (!arst_n)
		ready |-> status_word.range_sel == $past(high_freq_range_select))
		else $error("range bit wrong");
	chk_max_current: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(max_excitation) |-> $past(short_circuit)) else $error("max current no cause");
	chk_reduce_cause: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(reduce_excitation) |-> $past(excit_overcurrent)) else $error("reduce no cause");
	chk_led_half: assert property (@(posedge clk) disable iff (!arst_n)
		ready |-> run_len <= 32'(FLASH_CYC / 2 + 3)) else $error("indicator level too long");

endmodule : ras_supervisor_chk

bind ras_supervisor ras_supervisor_chk #(.FLASH_CYC(FLASH_CYC)) ras_supervisor_chk_i (
	.clk(clk), .arst_n(arst_n), .loc_req(loc_req),
	.high_freq_range_select(high_freq_range_select), .over_voltage(over_voltage),
	.short_circuit(short_circuit), .excit_overcurrent(excit_overcurrent),
	.loc_rdata(loc_rdata), .loc_rvalid(loc_rvalid), .max_excitation(max_excitation),
	.reduce_excitation(reduce_excitation), .status_word(status_word),
	.indicator_led(indicator_led)
);

`default_nettype wire

//--- ras_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module ras_host_model import ras_pkg::*; (
	// Clock
	input wire logic clk,
	// Parameter port
	output var ras_loc_req_t loc_req,
	input wire logic [15:0] loc_rdata,
	input wire logic loc_rvalid
);
	initial loc_req = '0;
	// One word written; lines show inverted values once idle
	task automatic write_loc(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		loc_req <= {1'b1, 1'b0, a, d};
		@(posedge clk);
		loc_req <= {1'b0, 1'b0, ~a, ~d};
	endtask : write_loc
	// One word read; answer taken at the rising edge where it stands
	task automatic read_loc(input logic [7:0] a, output logic [15:0] d);
		d = 16'hxxxx;
		@(posedge clk);
		loc_req <= {1'b0, 1'b1, a, 16'h0000};
		@(posedge clk);
		loc_req <= {1'b0, 1'b0, ~a, 16'hffff};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			if (loc_rvalid === 1'b1) begin
				d = loc_rdata;
				break;
			end
		end
	endtask : read_loc
endmodule : ras_host_model

`default_nettype wire

//--- ras_supervisor_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module ras_supervisor_tb_top import ras_pkg::*; ();
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [15:0] freq = 16'h0000;
	logic [15:0] under_f = 16'h0000;
	logic range_sel = 1'b0;
	logic cks = 1'b0;
	logic [3:0] cond = 4'h0;
	logic [6:0] mask = 7'h7f;
	logic [3:0] delay_s = 4'h0;
	ras_loc_req_t loc_req;
	ras_status_t status;
	logic [15:0] loc_rdata, slope, vout;
	logic loc_rvalid, prot, max_exc, red_exc, reg_en, led;
	int failures = 0;
	int checked = 0;
	int n, r;
	// Overspeed cases: setting, range, frequency, status
	logic [63:0] ovs [10] = '{64'h0000_0000_157d_0040, 64'h0000_0000_157c_0800,
		64'h0000_0001_19c9_8040, 64'h0000_0001_19c8_8800, 64'h8000_0000_1389_0040,
		64'h8000_0000_1388_0800, 64'h8000_0001_1771_8040, 64'h7fff_0000_1771_0040,
		64'h7fff_0000_1770_0800, 64'h7fff_0001_1c21_8040};

	// Clock
	always #2.5 clk = ~clk;

	ras_supervisor #(.TENTH_CYC(20), .FLASH_CYC(16)) ras_supervisor_i (
		.clk(clk), .arst_n(arst_n), .loc_req(loc_req), .loc_rdata(loc_rdata),
		.loc_rvalid(loc_rvalid), .freq(freq), .underspeed_freq(under_f),
		.high_freq_range_select(range_sel), .checksum_fail(cks), .over_voltage(cond[0]),
		.under_voltage(cond[1]), .short_circuit(cond[2]), .excit_overcurrent(cond[3]),
		.prot_mask(mask), .prot_delay_s(delay_s), .run_vf_slope(16'h2328),
		.vout_request(16'h0800), .aux_supply_min(16'h1000), .protection_output(prot),
		.max_excitation(max_exc), .reduce_excitation(red_exc), .regulator_enable(reg_en),
		.active_vf_slope(slope), .vout_setpoint(vout), .status_word(status),
		.indicator_led(led)
	);

	ras_host_model ras_host_model_i (
		.clk(clk), .loc_req(loc_req), .loc_rdata(loc_rdata), .loc_rvalid(loc_rvalid)
	);

	// Comparison and bookkeeping
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		ras_host_model_i.write_loc(a, d);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		ras_host_model_i.read_loc(a, d);
		check(d, exp);
	endtask : rd_chk
	task automatic settle();
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask : settle
	task automatic set_f(input logic [15:0] f);
		@(posedge clk);
		freq <= f;
		settle();
	endtask : set_f
	// Lamp samples over 32 cycles: cycles lit and rising edges
	task automatic led_scan(output int hi, output int rise);
		logic prev;
		hi = 0;
		rise = 0;
		@(negedge clk);
		prev = led;
		for (int i = 0; i < 32; i++) begin
			@(negedge clk);
			if (led === 1'b1) hi++;
			if (led === 1'b1 && prev === 1'b0) rise++;
			prev = led;
		end
	endtask : led_scan
	task automatic en_is(input logic b);
		@(negedge clk);
		check({15'h0, reg_en}, {15'h0, b});
	endtask : en_is
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	// Watchdog, far beyond the fewer than a thousand cycles of the run
	initial begin
		#200000;
		failures++;
		give_verdict();
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(LOC_STARTUP_SLOPE, 16'h2ee0);
		rd_chk(8'h30, 16'h0000);
		wr(LOC_ALARM_STATUS, 16'hffff);
		rd_chk(LOC_ALARM_STATUS, 16'h0800);
		led_scan(n, r);
		check(16'(n), 16'h0010);
		check(16'(r), 16'h0002);
		// Start-up slope and voltage floor
		wr(LOC_AUX_COEF, 16'h0000);
		@(posedge clk);
		under_f <= 16'h1194;
		set_f(16'h0bb8);
		check(slope, 16'h2ee0);
		check(vout, 16'h1000);
		// Auxiliary winding at half the output voltage doubles the floor
		wr(LOC_AUX_COEF, 16'h7fff);
		settle();
		check(vout, 16'h2000);
		led_scan(n, r);
		check(16'(r), 16'h0008);
		set_f(16'h1388);
		check(slope, 16'h2328);
		check(vout, 16'h0800);
		@(posedge clk);
		under_f <= 16'h0000;
		foreach (ovs[i]) begin
			wr(LOC_OVERSPEED, ovs[i][63:48]);
			@(posedge clk);
			range_sel <= ovs[i][32];
			set_f(ovs[i][31:16]);
			rd_chk(LOC_ALARM_STATUS, ovs[i][15:0]);
		end
		// Each of the four condition inputs and its actions
		@(posedge clk);
		range_sel <= 1'b0;
		set_f(16'h0bb8);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			cond <= 4'h1 << i;
			settle();
			rd_chk(LOC_ALARM_STATUS, 16'h0002 << i);
			check({15'h0, prot}, 16'h0001);
			check({14'h0, red_exc, max_exc}, (i > 1) ? 16'(i - 1) : 16'h0);
		end
		// Masked alarm stays off the output; a one-second delay holds it back
		@(posedge clk);
		cond <= 4'h1;
		mask <= 7'h7d;
		settle();
		check({15'h0, prot}, 16'h0000);
		@(posedge clk);
		cond <= 4'h0;
		mask <= 7'h7f;
		delay_s <= 4'h1;
		@(posedge clk);
		cond <= 4'h1;
		repeat (170) @(posedge clk);
		@(negedge clk);
		check({15'h0, prot}, 16'h0000);
		repeat (40) @(posedge clk);
		@(negedge clk);
		check({15'h0, prot}, 16'h0001);
		@(posedge clk);
		cond <= 4'h0;
		delay_s <= 4'h0;
		set_f(16'h05dc);
		en_is(1'b0);
		set_f(16'h0bb8);
		en_is(1'b0);
		set_f(16'h0000);
		en_is(1'b1);
		set_f(16'h0bb8);
		// Short-circuit tolerance, restart and expiry; 40 cycles hold two ticks
		wr(LOC_SC_TIME, 16'h1203);
		rd_chk(LOC_SC_TIME, 16'h0003);
		for (int k = 0; k < 2; k++) begin
			repeat (2) @(posedge clk);
			cond <= 4'h4;
			repeat (40) @(posedge clk);
			cond <= 4'h0;
			en_is(1'b1);
		end
		@(posedge clk);
		cond <= 4'h4;
		repeat (70) @(posedge clk);
		en_is(1'b0);
		@(posedge clk);
		cond <= 4'h0;
		wr(LOC_SC_TIME, 16'h0000);
		set_f(16'h0000);
		set_f(16'h0bb8);
		@(posedge clk);
		cond <= 4'h4;
		repeat (150) @(posedge clk);
		en_is(1'b1);
		// Checksum failure
		@(posedge clk);
		cond <= 4'h0;
		wr(LOC_STARTUP_SLOPE, 16'h1111);
		@(posedge clk);
		cks <= 1'b1;
		@(posedge clk);
		cks <= 1'b0;
		settle();
		en_is(1'b0);
		rd_chk(LOC_STARTUP_SLOPE, 16'h2ee0);
		rd_chk(LOC_ALARM_STATUS, 16'h0001);
		give_verdict();
	end
endmodule : ras_supervisor_tb_top

`default_nettype wire
